// ### bench/diag_host_model.sv
// host controller model driving the two-wire management bus
`timescale 1ns/1ps
`default_nettype none
module diag_host_model
    import diag_flag_pkg::*;
#(
    parameter int HALF = 6
) (
    input  wire logic clk,
    input  wire logic sdaOut,
    input  wire logic sdaOe,
    output var logic  scl,
    output logic      sdaIn
);
    logic hostLow;

    // open-drain data line with pull-up, either party may pull low
    assign sdaIn = !(hostLow || (sdaOe && !sdaOut));

    // clock line idles high between frames
    initial begin
        scl = 1'b1;
        hostLow = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus phases, all changes just after a clock edge
    task automatic half();
        repeat (HALF) @(posedge clk);
    endtask : half

    task automatic bit_io(input logic b, output logic s);
        @(posedge clk);
        hostLow <= !b;
        half();
        scl <= 1'b1;
        half();
        s = sdaIn;
        scl <= 1'b0;
    endtask : bit_io

    task automatic start();
        @(posedge clk);
        hostLow <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        hostLow <= 1'b1;
        half();
        scl <= 1'b0;
    endtask : start

    task automatic stop();
        @(posedge clk);
        hostLow <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        hostLow <= 1'b0;
        half();
    endtask : stop

    ////////////////////////////////////////////////////////////////////////////
    // byte level, msb first, ack slot after each byte
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : send

    task automatic recv(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(!more, s);
    endtask : recv

    // eight bytes from offset, repeated start between address and data
    task automatic rd(input logic [7:0] ofs, output logic [63:0] pg, output logic ok);
        logic       a0;
        logic       a1;
        logic       a2;
        logic [7:0] d;
        start();
        send({DEV_ADDR, 1'b0}, a0);
        send(ofs, a1);
        start();
        send({DEV_ADDR, 1'b1}, a2);
        for (int i = 0; i < 8; i++) begin
            recv(i < 7, d);
            pg[63-8*i -: 8] = d;
        end
        stop();
        ok = a0 && a1 && a2;
    endtask : rd

    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                      output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start();
        send({dev, 1'b0}, a0);
        send(ofs, a1);
        send(d, a2);
        stop();
        ok = a0 && a1 && a2;
    endtask : wr
endmodule : diag_host_model
`default_nettype wire

// ### bench/test_diag_threshold_flag_bank.sv
// self-checking bench for the diagnostic flag bank
`timescale 1ns/1ps
`default_nettype none
module test_diag_threshold_flag_bank
    import diag_flag_pkg::*;
;
    logic         clk;
    logic         rst_n;
    meas_set_t    measValue;
    logic         measUpdate;
    logic         measValid;
    limit_table_t limits;
    logic         scl;
    logic         sdaIn;
    logic         sdaOut;
    logic         sdaOe;
    logic         dataReadyBar;
    int           nMismatch;
    int           checksDone;

    diag_threshold_flag_bank i_diag_threshold_flag_bank (
        .clk(clk), .rst_n(rst_n), .measValue(measValue), .measUpdate(measUpdate),
        .measValid(measValid), .limits(limits), .scl(scl), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .dataReadyBar(dataReadyBar)
    );

    diag_host_model i_diag_host_model (
        .clk(clk), .sdaOut(sdaOut), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn)
    );

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic gt(input logic s, input meas_word_t x, input meas_word_t y);
        return s ? ($signed(x) > $signed(y)) : (x > y);
    endfunction : gt

    function automatic flag_set_t cmp(input logic s, input meas_word_t v, input limit_set_t l);
        return '{gt(s, v, l.highAlarm), gt(s, l.lowAlarm, v),
                 gt(s, v, l.highWarn), gt(s, l.lowWarn, v)};
    endfunction : cmp

    // bytes 6E..75 as the host should read them
    function automatic logic [63:0] page(input meas_set_t v, input limit_table_t l,
                                         input logic nrdy);
        logic [7:0] a;
        logic [7:0] w;
        flag_set_t  f;
        for (int c = 0; c < 4; c++) begin
            f = cmp(c == MEAS_TEMP, v[c], l[c]);
            a[7-2*c -: 2] = {f.highAlarm, f.lowAlarm};
            w[7-2*c -: 2] = {f.highWarn, f.lowWarn};
        end
        f = cmp(1'b0, v[MEAS_RXPWR], l[MEAS_RXPWR]);
        return {7'h00, nrdy, 8'h00, a, f.highAlarm, f.lowAlarm, 6'h00, 16'h0000,
                w, f.highWarn, f.lowWarn, 6'h00};
    endfunction : page

    // mostly a limit plus -1, 0 or +1 to hit the strict compare edges
    function automatic meas_word_t pick(input limit_set_t l);
        int k;
        k = $urandom_range(0, 4);
        if (k == 4) return meas_word_t'($urandom);
        return l[63-16*k -: 16] + meas_word_t'($urandom_range(0, 2)) - 16'h0001;
    endfunction : pick

    ////////////////////////////////////////////////////////////////////////////
    // comparison and closing
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        checksDone++;
        if (g !== e) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic check_page(input logic [63:0] e, input logic [63:0] g);
        for (int i = 0; i < 8; i++) begin
            check($sformatf("byte %h", OFS_STATUS_CONTROL + i), e[63-8*i -: 8], g[63-8*i -: 8]);
        end
    endtask : check_page

    task automatic complete_run();
        $display("mismatches %0d checks %0d", nMismatch, checksDone);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task automatic upd(input meas_set_t v);
        measValue  <= v;
        measUpdate <= 1'b1;
        @(posedge clk);
    endtask : upd

    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        nMismatch++;
        $display("BAD watchdog expected done seen running");
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [63:0]  got;
        logic         ok;
        meas_set_t    v;
        meas_set_t    junk;
        limit_table_t lt;
        void'($urandom(32'h682B0404));
        nMismatch = 0;
        checksDone = 0;
        rst_n = 1'b0;
        measValue = '0;
        measUpdate = 1'b0;
        measValid = 1'b0;
        limits = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        measValid <= 1'b1;
        repeat (3) @(posedge clk);
        // valid but no sample taken yet: still not ready
        check("ready pin", 8'h01, {7'h00, dataReadyBar});
        i_diag_host_model.rd(OFS_STATUS_CONTROL, got, ok);
        check("read ack", 8'h01, {7'h00, ok});
        check_page({8'h01, 56'h0}, got);
        for (int n = 0; n < 20; n++) begin
            foreach (lt[c]) lt[c] = {$urandom, $urandom};
            foreach (v[c]) v[c] = pick(lt[c]);
            foreach (junk[c]) junk[c] = meas_word_t'($urandom);
            limits <= lt;
            @(posedge clk);
            // back-to-back updates, the second one must win
            upd(junk);
            upd(v);
            measUpdate <= 1'b0;
            measValue <= ~v;
            @(posedge clk);
            check("ready pin", 8'h00, {7'h00, dataReadyBar});
            i_diag_host_model.rd(OFS_STATUS_CONTROL, got, ok);
            check("read ack", 8'h01, {7'h00, ok});
            check_page(page(v, lt, 1'b0), got);
            check_page(page(v, lt, 1'b0), got);
            check_page(page(v, lt, 1'b0), got);
            check_page(page(v, lt, 1'b0), got);
        end
        measValid <= 1'b0;
        repeat (2) @(posedge clk);
        check("ready pin", 8'h01, {7'h00, dataReadyBar});
        // write is acked but dropped, other device address is ignored
        i_diag_host_model.wr(DEV_ADDR, OFS_ALARM_PRIMARY, 8'hFF, ok);
        check("write ack", 8'h01, {7'h00, ok});
        i_diag_host_model.wr(7'h50, OFS_WARN_PRIMARY, 8'hFF, ok);
        check("foreign ack", 8'h00, {7'h00, ok});
        i_diag_host_model.rd(OFS_STATUS_CONTROL, got, ok);
        check("read ack", 8'h01, {7'h00, ok});
        check_page(page(v, lt, 1'b1), got);
        check("sda drive", 8'h00, {6'h00, sdaOut, sdaOe});
        complete_run();
    end
endmodule : test_diag_threshold_flag_bank
`default_nettype wire

// ### design/diag_flag_pkg.sv
// shared constants and carrier types for the diagnostic flag bank
package diag_flag_pkg;

    // measurement channels
    localparam int NUM_MEAS      = 5;
    localparam int MEAS_TEMP     = 0;
    localparam int MEAS_SUPPLY   = 1;
    localparam int MEAS_BIAS     = 2;
    localparam int MEAS_TXPWR    = 3;
    localparam int MEAS_RXPWR    = 4;
    localparam int MEAS_WIDTH    = 16;

    // two-wire bus: 7-bit device address of the diagnostic page
    localparam logic [6:0] DEV_ADDR = 7'h51;

    // byte offsets on the diagnostic page
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h6E;
    localparam logic [7:0] OFS_ALARM_PRIMARY  = 8'h70;
    localparam logic [7:0] OFS_ALARM_RECEIVE  = 8'h71;
    localparam logic [7:0] OFS_WARN_PRIMARY   = 8'h74;
    localparam logic [7:0] OFS_WARN_RECEIVE   = 8'h75;

    // field positions
    localparam int BIT_TEMP_HIGH   = 7;
    localparam int BIT_TEMP_LOW    = 6;
    localparam int BIT_SUPPLY_HIGH = 5;
    localparam int BIT_SUPPLY_LOW  = 4;
    localparam int BIT_BIAS_HIGH   = 3;
    localparam int BIT_BIAS_LOW    = 2;
    localparam int BIT_TXPWR_HIGH  = 1;
    localparam int BIT_TXPWR_LOW   = 0;
    localparam int BIT_RXPWR_HIGH  = 7;
    localparam int BIT_RXPWR_LOW   = 6;
    localparam int BIT_DATA_NREADY = 0;

    // reset values
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic       NREADY_RESET  = 1'b1;

    typedef logic [MEAS_WIDTH-1:0] meas_word_t;
    typedef meas_word_t [NUM_MEAS-1:0] meas_set_t;

    typedef struct packed {
        meas_word_t highAlarm;
        meas_word_t lowAlarm;
        meas_word_t highWarn;
        meas_word_t lowWarn;
    } limit_set_t;

    typedef limit_set_t [NUM_MEAS-1:0] limit_table_t;

    typedef struct packed {
        logic highAlarm;
        logic lowAlarm;
        logic highWarn;
        logic lowWarn;
    } flag_set_t;

    typedef flag_set_t [NUM_MEAS-1:0] flag_table_t;

    // two-wire slave states
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_WADDR, S_WADDR_ACK,
        S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
    } serial_state_t;

endpackage : diag_flag_pkg

// ### design/diag_limit_compare.sv
// one measurement against its four limits, refreshed on each update
`timescale 1ns/1ps
`default_nettype none
module diag_limit_compare
    import diag_flag_pkg::*;
#(
    parameter bit IS_SIGNED = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       update,
    input  wire meas_word_t value,
    input  wire limit_set_t limits,
    output flag_set_t       flags
);

    flag_set_t state;
    flag_set_t next_state;

    // order-preserving key: flip sign bit for signed data
    function automatic meas_word_t orderKey(input meas_word_t v);
        orderKey = {v[MEAS_WIDTH-1] ^ IS_SIGNED, v[MEAS_WIDTH-2:0]};
    endfunction : orderKey

    // flags follow the present comparison, no latching
    always_comb begin
        next_state = state;
        if (update) begin
            next_state.highAlarm = orderKey(value) > orderKey(limits.highAlarm);
            next_state.lowAlarm  = orderKey(value) < orderKey(limits.lowAlarm);
            next_state.highWarn  = orderKey(value) > orderKey(limits.highWarn);
            next_state.lowWarn   = orderKey(value) < orderKey(limits.lowWarn);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flags = state;

endmodule : diag_limit_compare
`default_nettype wire

// ### design/diag_ready_track.sv
// active-low data-ready indication
`timescale 1ns/1ps
`default_nettype none
module diag_ready_track
    import diag_flag_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic measUpdate,
    input  wire logic measValid,
    output logic      readyBar
);

    logic state;
    logic next_state;

    // cleared on the first valid update, set again when data is lost
    always_comb begin
        next_state = state;
        if (!measValid) begin
            next_state = 1'b1;
        end else if (measUpdate) begin
            next_state = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= NREADY_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign readyBar = state;

endmodule : diag_ready_track
`default_nettype wire

// ### design/diag_threshold_flag_bank.sv
// diagnostic flag bank with its two-wire serial read access
//
// Behaviour
// RULE1 - temperature above high alarm limit sets byte 112 bit 7; below low sets bit 6
// RULE2 - temperature low alarm shows in byte 112 bit 6
// RULE3 - supply voltage above high alarm limit sets byte 112 bit 5
// RULE4 - supply voltage below low alarm limit sets byte 112 bit 4
// RULE5 - laser bias above high alarm limit sets byte 112 bit 3
// RULE6 - laser bias below low alarm limit sets byte 112 bit 2
// RULE7 - transmit power above high alarm limit sets byte 112 bit 1
// RULE8 - transmit power below low alarm limit sets byte 112 bit 0
// RULE9 - receive power high alarm in byte 113 bit 7; low in bit 6; rest reserved
// RULE10 - receive power below low alarm limit sets byte 113 bit 6
// RULE11 - temperature high and low warnings in byte 116 bits 7 and 6
// RULE12 - supply voltage high and low warnings in byte 116 bits 5 and 4
// RULE13 - laser bias high and low warnings in byte 116 bits 3 and 2
// RULE14 - transmit power high and low warnings in byte 116 bits 1 and 0
// RULE15 - receive power high warning in byte 117 bit 7, low warning also there
// RULE16 - active-low data-ready bit clears only once valid measurements exist
// RULE17 - low flags mean below limit; receive low warning bit 6; reserved read zero
// RULE18 - every flag recomputed on each update, following the present comparison
`timescale 1ns/1ps
`default_nettype none
module diag_threshold_flag_bank
    import diag_flag_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire meas_set_t    measValue,
    input  wire logic         measUpdate,
    input  wire logic         measValid,
    input  wire limit_table_t limits,
    input  wire logic         scl,
    input  wire logic         sdaIn,
    output logic              sdaOut,
    output logic              sdaOe,
    output logic              dataReadyBar
);

    // all checks run on the one clock and rest during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // comparators

    flag_table_t flags;
    logic        readyBar;

    // one comparator per measurement, temperature is signed
    for (genvar i = 0; i < NUM_MEAS; i++) begin : g_cmp
        diag_limit_compare #(
            .IS_SIGNED (i == MEAS_TEMP)
        ) u_cmp (
            .clk    (clk),
            .rst_n  (rst_n),
            .update (measUpdate),      // see RULE18
            .value  (measValue[i]),
            .limits (limits[i]),
            .flags  (flags[i])
        );
    end

    diag_ready_track u_ready (
        .clk        (clk),
        .rst_n      (rst_n),
        .measUpdate (measUpdate),
        .measValid  (measValid),
        .readyBar   (readyBar)        // see RULE16
    );

    assign dataReadyBar = readyBar;

    a_ready_needs_valid: assert property ( // see RULE16
        !measValid |=> dataReadyBar)
        else $error("ready shown without valid data");
    a_ready_clears: assert property ( // see RULE16
        measValid && measUpdate |=> !dataReadyBar)
        else $error("ready not shown after valid update");

    ////////////////////////////////////////////////////////////////////////
    // flag bytes

    logic [7:0] alarmPrimary;
    logic [7:0] alarmReceive;
    logic [7:0] warnPrimary;
    logic [7:0] warnReceive;
    logic [7:0] statusControl;

    // alarm byte assembly
    always_comb begin
        alarmPrimary                  = FLAGS_RESET;
        alarmPrimary[BIT_TEMP_HIGH]   = flags[MEAS_TEMP].highAlarm;    // see RULE1
        alarmPrimary[BIT_TEMP_LOW]    = flags[MEAS_TEMP].lowAlarm;     // see RULE2
        alarmPrimary[BIT_SUPPLY_HIGH] = flags[MEAS_SUPPLY].highAlarm;  // see RULE3
        alarmPrimary[BIT_SUPPLY_LOW]  = flags[MEAS_SUPPLY].lowAlarm;   // see RULE4
        alarmPrimary[BIT_BIAS_HIGH]   = flags[MEAS_BIAS].highAlarm;    // see RULE5
        alarmPrimary[BIT_BIAS_LOW]    = flags[MEAS_BIAS].lowAlarm;     // see RULE6
        alarmPrimary[BIT_TXPWR_HIGH]  = flags[MEAS_TXPWR].highAlarm;   // see RULE7
        alarmPrimary[BIT_TXPWR_LOW]   = flags[MEAS_TXPWR].lowAlarm;    // see RULE8
        alarmReceive                  = FLAGS_RESET;                   // see RULE17
        alarmReceive[BIT_RXPWR_HIGH]  = flags[MEAS_RXPWR].highAlarm;   // see RULE9
        alarmReceive[BIT_RXPWR_LOW]   = flags[MEAS_RXPWR].lowAlarm;    // see RULE10
    end

    // warning byte assembly
    always_comb begin
        warnPrimary                  = FLAGS_RESET;
        warnPrimary[BIT_TEMP_HIGH]   = flags[MEAS_TEMP].highWarn;      // see RULE11
        warnPrimary[BIT_TEMP_LOW]    = flags[MEAS_TEMP].lowWarn;       // see RULE11
        warnPrimary[BIT_SUPPLY_HIGH] = flags[MEAS_SUPPLY].highWarn;    // see RULE12
        warnPrimary[BIT_SUPPLY_LOW]  = flags[MEAS_SUPPLY].lowWarn;     // see RULE12
        warnPrimary[BIT_BIAS_HIGH]   = flags[MEAS_BIAS].highWarn;      // see RULE13
        warnPrimary[BIT_BIAS_LOW]    = flags[MEAS_BIAS].lowWarn;       // see RULE13
        warnPrimary[BIT_TXPWR_HIGH]  = flags[MEAS_TXPWR].highWarn;     // see RULE14
        warnPrimary[BIT_TXPWR_LOW]   = flags[MEAS_TXPWR].lowWarn;      // see RULE14
        warnReceive                  = FLAGS_RESET;                    // see RULE17
        warnReceive[BIT_RXPWR_HIGH]  = flags[MEAS_RXPWR].highWarn;     // see RULE15
        warnReceive[BIT_RXPWR_LOW]   = flags[MEAS_RXPWR].lowWarn;      // see RULE17
        statusControl                = FLAGS_RESET;
        statusControl[BIT_DATA_NREADY] = readyBar;                     // see RULE16
    end

    // each flag byte follows the compare of the sample taken at the update
    a_temp_high_alarm: assert property (measUpdate |=> // see RULE1
        alarmPrimary[BIT_TEMP_HIGH] ==
        ($signed($past(measValue[MEAS_TEMP])) > $signed($past(limits[MEAS_TEMP].highAlarm))))
        else $error("temperature high alarm wrong");

    a_temp_low_alarm: assert property (measUpdate |=> // see RULE2
        alarmPrimary[BIT_TEMP_LOW] ==
        ($signed($past(measValue[MEAS_TEMP])) < $signed($past(limits[MEAS_TEMP].lowAlarm))))
        else $error("temperature low alarm wrong");

    a_supply_high_alarm: assert property (measUpdate |=> // see RULE3
        alarmPrimary[BIT_SUPPLY_HIGH] ==
        ($past(measValue[MEAS_SUPPLY]) > $past(limits[MEAS_SUPPLY].highAlarm)))
        else $error("supply high alarm wrong");

    a_supply_low_alarm: assert property (measUpdate |=> // see RULE4
        alarmPrimary[BIT_SUPPLY_LOW] ==
        ($past(measValue[MEAS_SUPPLY]) < $past(limits[MEAS_SUPPLY].lowAlarm)))
        else $error("supply low alarm wrong");

    a_bias_alarms: assert property (measUpdate |=> // see RULE5, RULE6
        alarmPrimary[BIT_BIAS_HIGH:BIT_BIAS_LOW] ==
        {$past(measValue[MEAS_BIAS]) > $past(limits[MEAS_BIAS].highAlarm),
         $past(measValue[MEAS_BIAS]) < $past(limits[MEAS_BIAS].lowAlarm)})
        else $error("bias alarms wrong");

    a_txpwr_alarms: assert property (measUpdate |=> // see RULE7, RULE8
        alarmPrimary[BIT_TXPWR_HIGH:BIT_TXPWR_LOW] ==
        {$past(measValue[MEAS_TXPWR]) > $past(limits[MEAS_TXPWR].highAlarm),
         $past(measValue[MEAS_TXPWR]) < $past(limits[MEAS_TXPWR].lowAlarm)})
        else $error("transmit power alarms wrong");

    a_rx_alarm_byte: assert property (measUpdate |=> // see RULE9, RULE10
        alarmReceive ==
        {$past(measValue[MEAS_RXPWR]) > $past(limits[MEAS_RXPWR].highAlarm),
         $past(measValue[MEAS_RXPWR]) < $past(limits[MEAS_RXPWR].lowAlarm), 6'h00})
        else $error("receive alarm byte wrong");

    a_temp_warnings: assert property (measUpdate |=> // see RULE11
        warnPrimary[BIT_TEMP_HIGH:BIT_TEMP_LOW] ==
        {$signed($past(measValue[MEAS_TEMP])) > $signed($past(limits[MEAS_TEMP].highWarn)),
         $signed($past(measValue[MEAS_TEMP])) < $signed($past(limits[MEAS_TEMP].lowWarn))})
        else $error("temperature warnings wrong");

    a_other_warnings: assert property (measUpdate |=> // see RULE12, RULE13, RULE14
        warnPrimary[BIT_SUPPLY_HIGH:BIT_TXPWR_LOW] ==
        {$past(measValue[MEAS_SUPPLY]) > $past(limits[MEAS_SUPPLY].highWarn),
         $past(measValue[MEAS_SUPPLY]) < $past(limits[MEAS_SUPPLY].lowWarn),
         $past(measValue[MEAS_BIAS]) > $past(limits[MEAS_BIAS].highWarn),
         $past(measValue[MEAS_BIAS]) < $past(limits[MEAS_BIAS].lowWarn),
         $past(measValue[MEAS_TXPWR]) > $past(limits[MEAS_TXPWR].highWarn),
         $past(measValue[MEAS_TXPWR]) < $past(limits[MEAS_TXPWR].lowWarn)})
        else $error("supply, bias or transmit warnings wrong");

    a_rx_warn_byte: assert property (measUpdate |=> // see RULE15, RULE17
        warnReceive ==
        {$past(measValue[MEAS_RXPWR]) > $past(limits[MEAS_RXPWR].highWarn),
         $past(measValue[MEAS_RXPWR]) < $past(limits[MEAS_RXPWR].lowWarn), 6'h00})
        else $error("receive warning byte wrong");

    a_flags_hold: assert property (!measUpdate |=> // see RULE18
        $stable(warnPrimary) && $stable(alarmPrimary))
        else $error("flags moved without update");

    // byte read decode, unmapped bytes read zero
    function automatic logic [7:0] readByte(input logic [7:0] addr);
        if (addr == OFS_ALARM_PRIMARY) begin
            readByte = alarmPrimary;
        end else if (addr == OFS_ALARM_RECEIVE) begin
            readByte = alarmReceive;
        end else if (addr == OFS_WARN_PRIMARY) begin
            readByte = warnPrimary;
        end else if (addr == OFS_WARN_RECEIVE) begin
            readByte = warnReceive;
        end else if (addr == OFS_STATUS_CONTROL) begin
            readByte = statusControl;
        end else begin
            readByte = FLAGS_RESET;
        end
    endfunction : readByte

    ////////////////////////////////////////////////////////////////////////
    // two-wire slave

    typedef struct packed {
        serial_state_t phase;
        logic          sclPrev;
        logic          sdaPrev;
        logic [3:0]    bitCnt;
        logic [7:0]    shift;
        logic [7:0]    wordAddr;
        logic          isRead;
        logic          masterNack;
        logic          sdaOe;
        logic          sdaOut;
    } slave_state_t;

    slave_state_t st;
    slave_state_t next_st;
    logic         sclRise;
    logic         sclFall;
    logic         startCond;
    logic         stopCond;
    logic [7:0]   loadByte;

    // bus event detection
    assign sclRise   = scl & ~st.sclPrev;
    assign sclFall   = ~scl & st.sclPrev;
    assign startCond = scl & st.sclPrev & st.sdaPrev & ~sdaIn;
    assign stopCond  = scl & st.sclPrev & ~st.sdaPrev & sdaIn;

    // byte the slave loads next, taken as a snapshot at the load
    always_comb begin
        loadByte = readByte(st.wordAddr);
    end

    // protocol sequencing: sample on scl rise, drive on scl fall
    always_comb begin
        next_st         = st;
        next_st.sclPrev = scl;
        next_st.sdaPrev = sdaIn;
        if (startCond) begin
            next_st.phase  = S_ADDR;
            next_st.bitCnt = 4'h0;
            next_st.sdaOe  = 1'b0;
        end else if (stopCond) begin
            next_st.phase = S_IDLE;
            next_st.sdaOe = 1'b0;
        end else if (sclRise) begin
            case (st.phase)
                S_ADDR, S_WADDR, S_WDATA: begin
                    next_st.shift  = {st.shift[6:0], sdaIn};
                    next_st.bitCnt = st.bitCnt + 4'h1;
                end
                S_RDATA_ACK: begin
                    next_st.masterNack = sdaIn;
                end
                default: begin
                end
            endcase
        end else if (sclFall) begin
            case (st.phase)
                S_ADDR: begin
                    if (st.bitCnt == 4'h8) begin
                        if (st.shift[7:1] == DEV_ADDR) begin
                            next_st.isRead = st.shift[0];
                            next_st.sdaOe  = 1'b1;
                            next_st.phase  = S_ADDR_ACK;
                        end else begin
                            next_st.phase = S_IDLE;
                        end
                    end
                end
                S_ADDR_ACK, S_RDATA_ACK: begin
                    if (st.phase == S_ADDR_ACK && !st.isRead) begin
                        next_st.sdaOe  = 1'b0;
                        next_st.bitCnt = 4'h0;
                        next_st.phase  = S_WADDR;
                    end else if (st.phase == S_RDATA_ACK && st.masterNack) begin
                        next_st.sdaOe = 1'b0;
                        next_st.phase = S_IDLE;
                    end else begin
                        next_st.shift  = loadByte << 1;
                        next_st.sdaOe  = ~loadByte[7];
                        next_st.bitCnt = 4'h1;
                        next_st.phase  = S_RDATA;
                    end
                end
                S_WADDR, S_WDATA: begin
                    if (st.bitCnt == 4'h8) begin
                        next_st.sdaOe = 1'b1;
                        next_st.phase = (st.phase == S_WADDR) ? S_WADDR_ACK : S_WDATA_ACK;
                    end
                end
                S_WADDR_ACK: begin
                    next_st.wordAddr = st.shift;
                    next_st.sdaOe    = 1'b0;
                    next_st.bitCnt   = 4'h0;
                    next_st.phase    = S_WDATA;
                end
                S_WDATA_ACK: begin
                    // flag bytes are read-only, written data is dropped
                    next_st.wordAddr = st.wordAddr + 8'h01;
                    next_st.sdaOe    = 1'b0;
                    next_st.bitCnt   = 4'h0;
                    next_st.phase    = S_WDATA;
                end
                S_RDATA: begin
                    if (st.bitCnt == 4'h8) begin
                        next_st.sdaOe    = 1'b0;
                        next_st.wordAddr = st.wordAddr + 8'h01;
                        next_st.phase    = S_RDATA_ACK;
                    end else begin
                        next_st.sdaOe  = ~st.shift[7];
                        next_st.shift  = st.shift << 1;
                        next_st.bitCnt = st.bitCnt + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st       <= '0;
            st.phase <= S_IDLE;
            st.sclPrev <= 1'b1;
            st.sdaPrev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // open drain: only ever pull low
    assign sdaOut = st.sdaOut;
    assign sdaOe  = st.sdaOe;

endmodule : diag_threshold_flag_bank
`default_nettype wire
